// *** hdl/partition_feature_page_map.v ***
`timescale 1ns/1ps
`include "partition_page_defines.vh"
// Summary of operation
// - Version bits 7:4 give fixed major revision
// - Version bits 3:0 give fixed minor revision
// - Low byte reads 01, 10 or 11, else 00
// - Only legal version pairs are ever reported
// - Forced non-secure exists only in v0.1
// - v0.1 forces secure requests to non-secure
// - Version register ignores writes from all pages
// - Version readable at 0x0020 in four pages
// - All four pages return identical version value
// - Version reads zero without partitioning feature
// - Root and Realm version read-only with extension
// - One shared feature page aliased into every security address map
// - Decode cache capacity and associativity controls
// - Decode 1024-word cache portion bitmap at 0x1000
// - Decode 128-word bandwidth portion bitmap at 0x2000
// - Decode 64-bit long counter and capture copy
// - Decode enable, disable and enable-flags registers
// - Decode overflow status and overflow message registers
// - Decode monitor select and capture trigger
// - Decode bandwidth min, max and window width
// - Decode priority, stride and narrowing registers
// - Decode storage counter, capture and overflow status
// - Reserved, write-only reads, read-only writes: RAZ/WI
module partition_feature_page_map #(
    parameter [3:0] MAJOR_REV = 4'h1,
    parameter [3:0] MINOR_REV = 4'h1,
    parameter HAS_PARTITIONING = 1,
    parameter HAS_FOUR_WORLD = 1,
    parameter HAS_CACHE_PART = 1,
    parameter HAS_BW_PART = 1,
    parameter HAS_MONITORS = 1,
    parameter CACHE_BITMAP_WORDS = `CACHE_BITMAP_WORDS,
    parameter BW_BITMAP_WORDS = `BW_BITMAP_WORDS
) (
    input wire clk_in,
    input wire rst_in,
    input wire req_valid_in,
    input wire req_write_in,
    input wire [1:0] req_world_in,
    input wire [13:0] req_addr_in,
    input wire [31:0] req_wdata_in,
    output reg resp_valid_out,
    output reg [31:0] resp_rdata_out,
    input wire storage_usage_inc_in,
    input wire bw_usage_inc_in,
    input wire req_secure_in,
    output wire req_nonsecure_out,
    output wire forced_nonsecure_partition_out,
    output wire [31:0] partition_enable_flags_out
);

// ----------------------------------------------------------------
// Version value
// ----------------------------------------------------------------
// Fixed at build time
// Upper 24 bits are reserved zeros
wire [7:0] ver_pair;
wire ver_legal;
wire [31:0] arch_version_id;

assign ver_pair = {MAJOR_REV, MINOR_REV};
// Illegal pairs collapse to zero rather than advertise a made-up version
assign ver_legal = (ver_pair == `VER_V0P1) || (ver_pair == `VER_V1P0) ||
                   (ver_pair == `VER_V1P1);
assign arch_version_id = (HAS_PARTITIONING != 0 && ver_legal) ?
                         {24'h000000, ver_pair[`VER_MAJOR_HI:`VER_MAJOR_LO],
                          ver_pair[`VER_MINOR_HI:`VER_MINOR_LO]} :
                         `RESET_WORD;

// Forcing is hardwired; no register can observe or steer it
// Constant flag; costs no logic
assign forced_nonsecure_partition_out = (arch_version_id[7:0] == `VER_V0P1);
assign req_nonsecure_out = ~req_secure_in | forced_nonsecure_partition_out;

// ----------------------------------------------------------------
// Page and feature decode
// ----------------------------------------------------------------
// One decoder serves all four pages
wire page_present;
wire feat_cache;
wire feat_bw;
wire feat_mon;
wire [13:0] cbm_end;
wire [13:0] bbm_end;
wire in_cbm;
wire in_bbm;
wire [9:0] cbm_idx;
wire [6:0] bbm_idx;
wire do_wr;
wire do_rd;

// Root and Realm pages exist only with the four-world extension
// so a page-less access is dropped, not aliased
assign page_present = (req_world_in == `WORLD_SECURE) ||
                      (req_world_in == `WORLD_NONSECURE) ||
                      (HAS_FOUR_WORLD != 0);
assign feat_cache = (HAS_PARTITIONING != 0) && (HAS_CACHE_PART != 0);
assign feat_bw = (HAS_PARTITIONING != 0) && (HAS_BW_PART != 0);
assign feat_mon = (HAS_PARTITIONING != 0) && (HAS_MONITORS != 0);
// Trimmed arrays leave a reserved tail
assign cbm_end = `OFS_CACHE_BITMAP + CACHE_BITMAP_WORDS[11:0] * 14'h0004;
assign bbm_end = `OFS_BW_BITMAP + BW_BITMAP_WORDS[11:0] * 14'h0004;
assign in_cbm = feat_cache && (req_addr_in >= `OFS_CACHE_BITMAP) &&
                (req_addr_in < cbm_end);
assign in_bbm = feat_bw && (req_addr_in >= `OFS_BW_BITMAP) &&
                (req_addr_in < bbm_end);
assign cbm_idx = req_addr_in[11:2];
assign bbm_idx = req_addr_in[8:2];
// Misaligned access never decodes
assign do_wr = req_valid_in && req_write_in && page_present && (req_addr_in[1:0] == 2'h0);
assign do_rd = req_valid_in && !req_write_in && page_present && (req_addr_in[1:0] == 2'h0);

// ----------------------------------------------------------------
// Storage
// ----------------------------------------------------------------
// Shared by every page
reg [31:0] cache_max_capacity_cfg_reg;
reg [31:0] cache_min_capacity_cfg_reg;
reg [31:0] cache_max_assoc_cfg_reg;
reg [31:0] bw_min_cfg_reg;
reg [31:0] bw_max_cfg_reg;
reg [31:0] bw_window_width_cfg_reg;
reg [31:0] partition_cfg_enable_flags_reg;
reg [31:0] priority_cfg_reg;
reg [31:0] bw_stride_cfg_reg;
reg [31:0] internal_partition_narrow_cfg_reg;
reg [31:0] monitor_instance_select_reg;
reg [31:0] storage_monitor_filter_reg;
reg [31:0] storage_monitor_control_reg;
reg [31:0] bw_monitor_filter_reg;
reg [31:0] bw_monitor_control_reg;
reg [31:0] storage_usage_count_reg;
reg [31:0] storage_usage_capture_reg;
reg [31:0] storage_overflow_status_reg;
reg [31:0] bw_usage_count_reg;
reg [31:0] bw_usage_capture_reg;
reg [63:0] bw_usage_long_count_reg;
reg [63:0] bw_usage_long_capture_reg;
reg [31:0] bw_overflow_status_reg;
reg [31:0] overflow_msg_partition_info_reg;
reg [31:0] overflow_msg_addr_low_reg;
reg [31:0] overflow_msg_addr_high_reg;
reg [31:0] overflow_msg_data_reg;
reg [31:0] overflow_msg_attributes_reg;
reg [31:0] monitor_overflow_status_reg;
// One word per bitmap index
reg [31:0] cache_portion_bitmap [0:CACHE_BITMAP_WORDS-1];
reg [31:0] bw_portion_bitmap [0:BW_BITMAP_WORDS-1];

assign partition_enable_flags_out = partition_cfg_enable_flags_reg;

// ----------------------------------------------------------------
// Monitor events
// ----------------------------------------------------------------
wire wr_hit;
wire capture_now;
wire csu_wrap;
wire bw_wrap;
wire [31:0] csu_next;
wire [31:0] bw_next;
wire [63:0] bwl_next;

// Capture takes pre-increment values
assign capture_now = feat_mon && do_wr && (req_addr_in == `OFS_CAPTURE_TRIGGER);
assign csu_next = storage_usage_count_reg + {31'h00000000, storage_usage_inc_in};
assign bw_next = bw_usage_count_reg + {31'h00000000, bw_usage_inc_in};
assign bwl_next = bw_usage_long_count_reg + {63'h0000000000000000, bw_usage_inc_in};
// Wrap is seen on the last count
// Long counter too wide to wrap
assign csu_wrap = feat_mon && storage_usage_inc_in && (storage_usage_count_reg == 32'hFFFFFFFF);
assign bw_wrap = feat_mon && bw_usage_inc_in && (bw_usage_count_reg == 32'hFFFFFFFF);
assign wr_hit = do_wr;

// Counters run on events; a software write to a counter takes priority
always @(posedge clk_in) begin
    if (rst_in) begin
        storage_usage_count_reg <= `RESET_WORD;
        bw_usage_count_reg <= `RESET_WORD;
        bw_usage_long_count_reg <= `RESET_LONG;
        storage_usage_capture_reg <= `RESET_WORD;
        bw_usage_capture_reg <= `RESET_WORD;
        bw_usage_long_capture_reg <= `RESET_LONG;
        storage_overflow_status_reg <= `RESET_WORD;
        bw_overflow_status_reg <= `RESET_WORD;
        monitor_overflow_status_reg <= `RESET_WORD;
    end else if (feat_mon) begin
        storage_usage_count_reg <= csu_next;
        bw_usage_count_reg <= bw_next;
        bw_usage_long_count_reg <= bwl_next;
        if (capture_now) begin
            storage_usage_capture_reg <= storage_usage_count_reg;
            bw_usage_capture_reg <= bw_usage_count_reg;
            bw_usage_long_capture_reg <= bw_usage_long_count_reg;
        end
        if (wr_hit) begin
            case (req_addr_in)
                `OFS_STORAGE_COUNT: storage_usage_count_reg <= req_wdata_in;
                `OFS_STORAGE_CAPTURE: storage_usage_capture_reg <= req_wdata_in;
                `OFS_BW_COUNT: bw_usage_count_reg <= req_wdata_in;
                `OFS_BW_CAPTURE: bw_usage_capture_reg <= req_wdata_in;
                `OFS_BW_LONG_LO: bw_usage_long_count_reg[31:0] <= req_wdata_in;
                `OFS_BW_LONG_HI: bw_usage_long_count_reg[63:32] <= req_wdata_in;
                `OFS_BW_LCAP_LO: bw_usage_long_capture_reg[31:0] <= req_wdata_in;
                `OFS_BW_LCAP_HI: bw_usage_long_capture_reg[63:32] <= req_wdata_in;
                `OFS_MON_OVF_STATUS: monitor_overflow_status_reg <= req_wdata_in;
                default: begin
                end
            endcase
        end
        // Overflow sets after any clear so a same-cycle wrap is kept
        if (csu_wrap) begin
            storage_overflow_status_reg[0] <= 1'b1;
            monitor_overflow_status_reg[0] <= 1'b1;
        end
        if (bw_wrap) begin
            bw_overflow_status_reg[0] <= 1'b1;
            monitor_overflow_status_reg[1] <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Configuration writes
// ----------------------------------------------------------------
// Read-only and unmapped slots simply fall to the default arm
always @(posedge clk_in) begin
    if (rst_in) begin
        cache_max_capacity_cfg_reg <= `RESET_WORD;
        cache_min_capacity_cfg_reg <= `RESET_WORD;
        cache_max_assoc_cfg_reg <= `RESET_WORD;
        bw_min_cfg_reg <= `RESET_WORD;
        bw_max_cfg_reg <= `RESET_WORD;
        bw_window_width_cfg_reg <= `RESET_WORD;
        partition_cfg_enable_flags_reg <= `RESET_WORD;
        priority_cfg_reg <= `RESET_WORD;
        bw_stride_cfg_reg <= `RESET_WORD;
        internal_partition_narrow_cfg_reg <= `RESET_WORD;
        monitor_instance_select_reg <= `RESET_WORD;
        storage_monitor_filter_reg <= `RESET_WORD;
        storage_monitor_control_reg <= `RESET_WORD;
        bw_monitor_filter_reg <= `RESET_WORD;
        bw_monitor_control_reg <= `RESET_WORD;
        overflow_msg_partition_info_reg <= `RESET_WORD;
        overflow_msg_addr_low_reg <= `RESET_WORD;
        overflow_msg_addr_high_reg <= `RESET_WORD;
        overflow_msg_data_reg <= `RESET_WORD;
        overflow_msg_attributes_reg <= `RESET_WORD;
    end else if (wr_hit) begin
        case (req_addr_in)
            `OFS_CACHE_MAX_CAP: if (feat_cache) cache_max_capacity_cfg_reg <= req_wdata_in;
            `OFS_CACHE_MIN_CAP: if (feat_cache) cache_min_capacity_cfg_reg <= req_wdata_in;
            `OFS_CACHE_MAX_ASSOC: if (feat_cache) cache_max_assoc_cfg_reg <= req_wdata_in;
            `OFS_BW_MIN: if (feat_bw) bw_min_cfg_reg <= req_wdata_in;
            `OFS_BW_MAX: if (feat_bw) bw_max_cfg_reg <= req_wdata_in;
            `OFS_BW_WINDOW: if (feat_bw) bw_window_width_cfg_reg <= req_wdata_in;
            // Low data bits pick the flag,
            // so no read-modify-write is needed
            `OFS_CFG_ENABLE: if (HAS_PARTITIONING != 0)
                partition_cfg_enable_flags_reg[req_wdata_in[4:0]] <= 1'b1;
            `OFS_CFG_DISABLE: if (HAS_PARTITIONING != 0)
                partition_cfg_enable_flags_reg[req_wdata_in[4:0]] <= 1'b0;
            `OFS_PRIORITY: if (HAS_PARTITIONING != 0) priority_cfg_reg <= req_wdata_in;
            `OFS_BW_STRIDE: if (feat_bw) bw_stride_cfg_reg <= req_wdata_in;
            `OFS_NARROW: if (HAS_PARTITIONING != 0)
                internal_partition_narrow_cfg_reg <= req_wdata_in;
            `OFS_MON_SELECT: if (feat_mon) monitor_instance_select_reg <= req_wdata_in;
            `OFS_STORAGE_FILTER: if (feat_mon) storage_monitor_filter_reg <= req_wdata_in;
            `OFS_STORAGE_CONTROL: if (feat_mon) storage_monitor_control_reg <= req_wdata_in;
            `OFS_BW_MON_FILTER: if (feat_mon) bw_monitor_filter_reg <= req_wdata_in;
            `OFS_BW_MON_CONTROL: if (feat_mon) bw_monitor_control_reg <= req_wdata_in;
            `OFS_MSG_PART_INFO: if (feat_mon) overflow_msg_partition_info_reg <= req_wdata_in;
            `OFS_MSG_ADDR_LO: if (feat_mon) overflow_msg_addr_low_reg <= req_wdata_in;
            `OFS_MSG_ADDR_HI: if (feat_mon) overflow_msg_addr_high_reg <= req_wdata_in;
            `OFS_MSG_DATA: if (feat_mon) overflow_msg_data_reg <= req_wdata_in;
            `OFS_MSG_ATTR: if (feat_mon) overflow_msg_attributes_reg <= req_wdata_in;
            default: begin
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Portion bitmaps
// ----------------------------------------------------------------
// Kept without reset so they map onto plain RAM
// A tail write misses both windows
always @(posedge clk_in) begin
    if (wr_hit && in_cbm) begin
        cache_portion_bitmap[cbm_idx] <= req_wdata_in;
    end
    if (wr_hit && in_bbm) begin
        bw_portion_bitmap[bbm_idx] <= req_wdata_in;
    end
end

// ----------------------------------------------------------------
// Read mux
// ----------------------------------------------------------------
// Answer is registered, so it
// always lands one cycle later
reg [31:0] rd_next;

// Version is the same wire for every world; no write path reaches it
// Misaligned and reserved give zero
// Write-only slots have no read arm
always @* begin
    rd_next = `RESET_WORD;
    if (in_cbm) begin
        rd_next = cache_portion_bitmap[cbm_idx];
    end else if (in_bbm) begin
        rd_next = bw_portion_bitmap[bbm_idx];
    end else begin
        case (req_addr_in)
            `OFS_ARCH_VERSION_ID: rd_next = arch_version_id;
            `OFS_CACHE_MAX_CAP: rd_next = feat_cache ? cache_max_capacity_cfg_reg : 32'h0;
            `OFS_CACHE_MIN_CAP: rd_next = feat_cache ? cache_min_capacity_cfg_reg : 32'h0;
            `OFS_CACHE_MAX_ASSOC: rd_next = feat_cache ? cache_max_assoc_cfg_reg : 32'h0;
            `OFS_BW_MIN: rd_next = feat_bw ? bw_min_cfg_reg : 32'h0;
            `OFS_BW_MAX: rd_next = feat_bw ? bw_max_cfg_reg : 32'h0;
            `OFS_BW_WINDOW: rd_next = feat_bw ? bw_window_width_cfg_reg : 32'h0;
            `OFS_CFG_ENABLE_FLAGS: rd_next = partition_cfg_enable_flags_reg;
            `OFS_PRIORITY: rd_next = priority_cfg_reg;
            `OFS_BW_STRIDE: rd_next = feat_bw ? bw_stride_cfg_reg : 32'h0;
            `OFS_NARROW: rd_next = internal_partition_narrow_cfg_reg;
            `OFS_MON_SELECT: rd_next = monitor_instance_select_reg;
            `OFS_STORAGE_FILTER: rd_next = storage_monitor_filter_reg;
            `OFS_STORAGE_CONTROL: rd_next = storage_monitor_control_reg;
            `OFS_BW_MON_FILTER: rd_next = bw_monitor_filter_reg;
            `OFS_BW_MON_CONTROL: rd_next = bw_monitor_control_reg;
            `OFS_STORAGE_COUNT: rd_next = storage_usage_count_reg;
            `OFS_STORAGE_CAPTURE: rd_next = storage_usage_capture_reg;
            `OFS_STORAGE_OVF: rd_next = storage_overflow_status_reg;
            `OFS_BW_COUNT: rd_next = bw_usage_count_reg;
            `OFS_BW_CAPTURE: rd_next = bw_usage_capture_reg;
            `OFS_BW_LONG_LO: rd_next = bw_usage_long_count_reg[31:0];
            `OFS_BW_LONG_HI: rd_next = bw_usage_long_count_reg[63:32];
            `OFS_BW_LCAP_LO: rd_next = bw_usage_long_capture_reg[31:0];
            `OFS_BW_LCAP_HI: rd_next = bw_usage_long_capture_reg[63:32];
            `OFS_BW_OVF: rd_next = bw_overflow_status_reg;
            `OFS_MSG_PART_INFO: rd_next = overflow_msg_partition_info_reg;
            `OFS_MSG_ADDR_LO: rd_next = overflow_msg_addr_low_reg;
            `OFS_MSG_ADDR_HI: rd_next = overflow_msg_addr_high_reg;
            `OFS_MSG_DATA: rd_next = overflow_msg_data_reg;
            `OFS_MSG_ATTR: rd_next = overflow_msg_attributes_reg;
            `OFS_MON_OVF_STATUS: rd_next = monitor_overflow_status_reg;
            default: rd_next = `RESET_WORD;
        endcase
    end
end

// ----------------------------------------------------------------
// Response
// ----------------------------------------------------------------
// Every request is answered one cycle later; writes answer with zero
// Refused accesses still answer,
// so no requester waits forever
always @(posedge clk_in) begin
    if (rst_in) begin
        resp_valid_out <= 1'b0;
        resp_rdata_out <= `RESET_WORD;
    end else begin
        resp_valid_out <= req_valid_in;
        resp_rdata_out <= do_rd ? rd_next : `RESET_WORD;
    end
end

endmodule

// *** hdl/partition_page_defines.vh ***
`ifndef PARTITION_PAGE_DEFINES_VH
`define PARTITION_PAGE_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets within one feature page
// ----------------------------------------------------------------
`define OFS_ARCH_VERSION_ID 14'h0020
`define OFS_CACHE_MAX_CAP 14'h0108
`define OFS_CACHE_MIN_CAP 14'h0110
`define OFS_CACHE_MAX_ASSOC 14'h0118
`define OFS_BW_MIN 14'h0200
`define OFS_BW_MAX 14'h0208
`define OFS_BW_WINDOW 14'h0220
`define OFS_CFG_ENABLE 14'h0300
`define OFS_CFG_DISABLE 14'h0310
`define OFS_CFG_ENABLE_FLAGS 14'h0320
`define OFS_PRIORITY 14'h0400
`define OFS_BW_STRIDE 14'h0500
`define OFS_NARROW 14'h0600
`define OFS_MON_SELECT 14'h0800
`define OFS_CAPTURE_TRIGGER 14'h0808
`define OFS_STORAGE_FILTER 14'h0810
`define OFS_STORAGE_CONTROL 14'h0818
`define OFS_BW_MON_FILTER 14'h0820
`define OFS_BW_MON_CONTROL 14'h0828
`define OFS_STORAGE_COUNT 14'h0840
`define OFS_STORAGE_CAPTURE 14'h0848
`define OFS_STORAGE_OVF 14'h0858
`define OFS_BW_COUNT 14'h0860
`define OFS_BW_CAPTURE 14'h0868
`define OFS_BW_LONG_LO 14'h0880
`define OFS_BW_LONG_HI 14'h0884
`define OFS_BW_LCAP_LO 14'h0890
`define OFS_BW_LCAP_HI 14'h0894
`define OFS_BW_OVF 14'h0898
`define OFS_MSG_PART_INFO 14'h08DC
`define OFS_MSG_ADDR_LO 14'h08E0
`define OFS_MSG_ADDR_HI 14'h08E4
`define OFS_MSG_DATA 14'h08E8
`define OFS_MSG_ATTR 14'h08EC
`define OFS_MON_OVF_STATUS 14'h08F0
`define OFS_CACHE_BITMAP 14'h1000
`define OFS_BW_BITMAP 14'h2000
`define OFS_PAGE_LIMIT 14'h3000

// ----------------------------------------------------------------
// Version field positions and legal values
// ----------------------------------------------------------------
`define VER_MAJOR_HI 7
`define VER_MAJOR_LO 4
`define VER_MINOR_HI 3
`define VER_MINOR_LO 0
`define VER_V0P1 8'h01
`define VER_V1P0 8'h10
`define VER_V1P1 8'h11

// ----------------------------------------------------------------
// Security worlds selecting a feature page
// ----------------------------------------------------------------
`define WORLD_SECURE 2'h0
`define WORLD_NONSECURE 2'h1
`define WORLD_ROOT 2'h2
`define WORLD_REALM 2'h3

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define RESET_WORD 32'h00000000
`define RESET_LONG 64'h0000000000000000
`define CACHE_BITMAP_WORDS 1024
`define BW_BITMAP_WORDS 128

`endif

// *** verif/page_map_checker_sva.sv ***
`timescale 1ns/1ps
`include "partition_page_defines.vh"
module page_map_checker #(
    parameter [3:0] MAJOR_REV = 4'h1,
    parameter [3:0] MINOR_REV = 4'h1
) (
    input wire clk_in,
    input wire rst_in,
    input wire req_valid_in,
    input wire req_write_in,
    input wire [13:0] req_addr_in,
    input wire [31:0] req_wdata_in,
    input wire resp_valid_out,
    input wire [31:0] resp_rdata_out,
    input wire req_secure_in,
    input wire req_nonsecure_out,
    input wire forced_nonsecure_partition_out,
    input wire [31:0] partition_enable_flags_out
);
    // ----------------------------------------------------------------
    // Bus, version, forcing and flag checks, one clock domain
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    localparam IS_V01 = (MAJOR_REV == 4'h0) && (MINOR_REV == 4'h1);
    wire rd = req_valid_in && !req_write_in;

    AST_RESP_NEXT: assert property (req_valid_in |=> resp_valid_out)
        else $error("request not answered next cycle");
    AST_NO_SPURIOUS: assert property (!req_valid_in |=> !resp_valid_out)
        else $error("response without request");
    AST_VER_MAJOR: assert property (rd && req_addr_in == 14'h0020 |=>
        {resp_rdata_out[31:8], resp_rdata_out[7:4]} == {24'h0, MAJOR_REV})
        else $error("version major field wrong");
    AST_VER_MINOR: assert property (rd && req_addr_in == 14'h0020 |=>
        resp_rdata_out[3:0] == MINOR_REV) else $error("version minor field wrong");
    AST_WO_READ_ZERO: assert property (rd && (req_addr_in == 14'h0300 ||
        req_addr_in == 14'h0310 || req_addr_in == 14'h0808) |=> resp_rdata_out == 32'h0)
        else $error("write-only location not read as zero");
    AST_FORCE_V01: assert property (forced_nonsecure_partition_out == IS_V01)
        else $error("forcing flag does not match version");
    AST_NS_FORCING: assert property (req_nonsecure_out ==
        (!req_secure_in || forced_nonsecure_partition_out)) else $error("bad space");
    // The flag register drives the port, so the bit shows at the next edge
    AST_FLAG_SET: assert property (req_valid_in && req_write_in &&
        req_addr_in == 14'h0300 |=>
        partition_enable_flags_out[$past(req_wdata_in[4:0])])
        else $error("enable write did not set flag");
endmodule

bind partition_feature_page_map page_map_checker #(
    .MAJOR_REV(MAJOR_REV),
    .MINOR_REV(MINOR_REV)
) chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
    .req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
    .resp_valid_out(resp_valid_out), .resp_rdata_out(resp_rdata_out),
    .req_secure_in(req_secure_in), .req_nonsecure_out(req_nonsecure_out),
    .forced_nonsecure_partition_out(forced_nonsecure_partition_out),
    .partition_enable_flags_out(partition_enable_flags_out)
);

// *** verif/tb_partition_feature_page_map.sv ***
`timescale 1ns/1ps
module tb_partition_feature_page_map;
    localparam [31:0] VER = {24'h0, 4'h1, 4'h1};
    logic clk_in, rst_in, req_valid_in, req_write_in, su_inc, bw_inc, req_secure_in;
    logic [1:0] req_world_in;
    logic [13:0] req_addr_in;
    logic [31:0] req_wdata_in, resp_rdata_out, flags, q;
    logic resp_valid_out, ns_out, force_out, v01_ns, v01_force;
    int n_tests = 0;
    int n_mismatch = 0;
    logic [13:0] ofs [22] = '{14'h0108, 14'h0110, 14'h0118, 14'h0200, 14'h0208, 14'h0220,
        14'h0400, 14'h0500, 14'h0600, 14'h0800, 14'h08DC, 14'h08E0, 14'h08E4, 14'h08E8,
        14'h08EC, 14'h0880, 14'h0884, 14'h0890, 14'h1000, 14'h1FFC, 14'h2000, 14'h21FC};

    partition_feature_page_map #(.MAJOR_REV(4'h1), .MINOR_REV(4'h1)) uut (
        .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_world_in(req_world_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .resp_valid_out(resp_valid_out),
        .resp_rdata_out(resp_rdata_out), .storage_usage_inc_in(su_inc),
        .bw_usage_inc_in(bw_inc), .req_secure_in(req_secure_in), .req_nonsecure_out(ns_out),
        .forced_nonsecure_partition_out(force_out), .partition_enable_flags_out(flags));

    // Second build at v0.1, where the forcing path is live
    partition_feature_page_map #(.MAJOR_REV(4'h0), .MINOR_REV(4'h1)) uut_v01 (
        .clk_in(clk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_world_in(req_world_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .resp_valid_out(), .resp_rdata_out(),
        .storage_usage_inc_in(su_inc), .bw_usage_inc_in(bw_inc), .req_secure_in(req_secure_in),
        .req_nonsecure_out(v01_ns), .forced_nonsecure_partition_out(v01_force),
        .partition_enable_flags_out());

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One access; the answer is registered, so it is taken a full cycle later
    task automatic acc(input logic wr, input logic [1:0] w, input logic [13:0] a,
            input logic [31:0] d);
        @(negedge clk_in);
        req_valid_in = 1'b1;
        req_write_in = wr;
        req_world_in = w;
        req_addr_in = a;
        req_wdata_in = d;
        @(negedge clk_in);
        req_valid_in = 1'b0;
        chk({31'h0, resp_valid_out}, 32'h1);
        q = resp_rdata_out;
        if (wr) chk(q, 32'h0);
    endtask

    task automatic rchk(input logic [1:0] w, input logic [13:0] a, input logic [31:0] e);
        acc(1'b0, w, a, 32'h0);
        chk(q, e);
    endtask

    task automatic pulse(input int n, input logic which);
        @(negedge clk_in);
        su_inc = !which;
        bw_inc = which;
        repeat (n) @(negedge clk_in);
        su_inc = 1'b0;
        bw_inc = 1'b0;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_version();
        for (int w = 0; w < 4; w++) begin
            rchk(w[1:0], 14'h0020, VER);
            acc(1'b1, w[1:0], 14'h0020, 32'hFFFFFFFF);
            rchk(w[1:0], 14'h0020, VER);
        end
        $display("test version done");
    endtask

    // Write all 22 listed slots first, then read all, so aliased decodes show up
    task automatic t_rw();
        for (int i = 0; i < 22; i++) acc(1'b1, i[1:0], ofs[i], {18'h3C5A5, ofs[i]});
        for (int i = 0; i < 22; i++) begin
            rchk(i[1:0] + 2'h1, ofs[i], {18'h3C5A5, ofs[i]});
        end
        $display("test read-write done");
    endtask

    task automatic t_refuse();
        acc(1'b1, 2'h1, 14'h0104, 32'hFFFFFFFF);
        acc(1'b1, 2'h1, 14'h0109, 32'h12345678);
        acc(1'b1, 2'h0, 14'h0320, 32'hFFFFFFFF);
        rchk(2'h1, 14'h0104, 32'h0);
        rchk(2'h1, 14'h0109, 32'h0);
        rchk(2'h1, 14'h0108, {18'h3C5A5, 14'h0108});
        rchk(2'h0, 14'h0320, 32'h0);
        rchk(2'h0, 14'h0300, 32'h0);
        rchk(2'h2, 14'h0310, 32'h0);
        rchk(2'h3, 14'h0808, 32'h0);
        $display("test refuse done");
    endtask

    task automatic t_enable();
        acc(1'b1, 2'h1, 14'h0300, 32'h5);
        rchk(2'h1, 14'h0320, 32'h20);
        chk(flags, 32'h20);
        acc(1'b1, 2'h0, 14'h0310, 32'h5);
        rchk(2'h0, 14'h0320, 32'h0);
        chk(flags, 32'h0);
        $display("test enable done");
    endtask

    // Storage counter wraps once; bandwidth counter counts three then is captured
    task automatic t_count();
        acc(1'b1, 2'h1, 14'h0840, 32'hFFFFFFFF);
        pulse(1, 1'b0);
        acc(1'b1, 2'h1, 14'h0860, 32'h10);
        pulse(3, 1'b1);
        acc(1'b1, 2'h1, 14'h0808, 32'h1);
        rchk(2'h1, 14'h0840, 32'h0);
        rchk(2'h1, 14'h0858, 32'h1);
        rchk(2'h1, 14'h08F0, 32'h1);
        rchk(2'h1, 14'h0848, 32'h0);
        rchk(2'h1, 14'h0868, 32'h13);
        $display("test counters done");
    endtask

    task automatic t_force();
        req_secure_in = 1'b1;
        @(negedge clk_in);
        chk({30'h0, ns_out, force_out}, 32'h0);
        chk({30'h0, v01_ns, v01_force}, 32'h3);
        req_secure_in = 1'b0;
        @(negedge clk_in);
        chk({30'h0, ns_out, force_out}, 32'h2);
        $display("test forcing done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    // Run needs about 0.92 us; the limit leaves wide margin
    initial begin
        #50000;
        n_mismatch++;
        test_done();
    end

    initial begin
        {rst_in, req_valid_in, req_write_in, su_inc, bw_inc, req_secure_in} = 6'h20;
        req_world_in = 2'h0;
        req_addr_in = 14'h0;
        req_wdata_in = 32'h0;
        repeat (20) @(negedge clk_in);
        rst_in = 1'b0;
        t_version();
        t_rw();
        t_refuse();
        t_enable();
        t_count();
        t_force();
        test_done();
    end
endmodule
